//--- pkg/gp6_regs.vh
/*
 Register map, field positions, reset values and timing counts of the
 single-pin control block. Assumes inclusion by bare name from verilog/.
*/
`ifndef GP6_REGS_VH
`define GP6_REGS_VH

// Register indices; byte address is four times the index
`define GP6_CFG_IDX 20'h0403d
`define GP6_CFG_ADDR 20'h100f4
`define GP6_LEVEL_ADDR 20'h00000
`define GP6_STATUS_ADDR 20'h00004

// Configuration fields
`define PIN_DIRECTION_BIT 15
`define PULL_SELECT_HI 14
`define PULL_SELECT_LO 13
`define GP6_IRQ_MODE_BIT 12
`define GP6_SUPPLY_BIT 11
`define PIN_POLARITY_BIT 10
`define OPEN_DRAIN_SELECT_BIT 9
`define PIN_ENABLE_BIT 7
`define PIN_FUNCTION_HI 3
`define PIN_FUNCTION_LO 0

`define GP6_CFG_RESET 16'ha400
`define GP6_CFG_MASK 16'hfe8f

// Pull codes
`define PULL_SELECT_NONE 2'h0
`define PULL_SELECT_DOWN 2'h1
`define PULL_SELECT_UP 2'h2

// Input function codes
`define GP6_FI_GPIO_LONG 4'h0
`define GP6_FI_GPIO 4'h1
`define GP6_FI_SLEEP_LONG 4'h4
`define GP6_FI_HWCTL1_LONG 4'he
`define GP6_FI_HWCTL2_LONG 4'hf

// Output function codes
`define GP6_FO_LEVEL 4'h0
`define GP6_FO_CLK32K 4'h1
`define GP6_FO_ON 4'h2
`define GP6_FO_SLEEP 4'h3
`define GP6_FO_CHANGE 4'h4
`define GP6_FO_VOLTAGE_SCALE_REQ_ONE 4'h8
`define GP6_FO_VOLTAGE_SCALE_REQ_TWO 4'h9
`define GP6_FO_EXTEN1 4'ha
`define GP6_FO_EXTEN2 4'hb
`define GP6_FO_SYSTEM_SUPPLY_GOOD 4'hc
`define GP6_FO_PGOOD 4'hd
`define GP6_FO_CLK2M 4'he
`define GP6_FO_AUXRST 4'hf

// Timing
`define GP6_LONG_DEB_CYCLES 16'h1000

// Bus responses
`define GP6_RESP_OKAY 2'h0
`define GP6_RESP_SLVERR 2'h2

`endif

//--- tb/gp6_board.sv
/*
 Board circuitry on the pin.
 Assumes the bench steers ext_en and ext_lvl.
*/
`timescale 1ns/1ns
`default_nettype none
module gp6_board (
  // Clock
  input wire logic clock,
  // Pad from block
  input wire logic pad_out,
  input wire logic pad_oe,
  input wire logic pull_up_en,
  input wire logic pull_down_en,
  // Board driver
  input wire logic ext_en,
  input wire logic ext_lvl,
  output logic pad_in
);
  logic wander_reg = 1'h0;
  // A floating pad drifts every cycle
  always @(posedge clock) wander_reg <= ~wander_reg;
  always_comb begin
    if (pad_oe) pad_in = pad_out;
    else if (ext_en) pad_in = ext_lvl;
    else if (pull_up_en) pad_in = 1'h1;
    else if (pull_down_en) pad_in = 1'h0;
    else pad_in = wander_reg;
  end
endmodule
`default_nettype wire

//--- tb/gp6_pin_props.sv
/*
 Port checker for the pin block.
 Assumes a bind from the bench top.
*/
`timescale 1ns/1ns
`default_nettype none
module gp6_pin_props (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pin side
  input wire logic pad_oe,
  input wire logic pull_up_en,
  input wire logic pull_down_en,
  input wire logic [15:0] role_in,
  input wire logic pin_irq_pulse
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_wr_lat;
    s_wr_both |=> ##1 s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
  property p_rd_lat;
    s_rd_take |=> s_axi_rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_b_clear;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_clear: assert property (p_b_clear) else $error("bvalid stuck");
  property p_r_clear;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_r_clear: assert property (p_r_clear) else $error("rvalid stuck");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
  property p_pull_excl;
    !(pull_up_en && pull_down_en);
  endproperty
  a_pull_excl: assert property (p_pull_excl) else $error("both pulls on");
  property p_hiz_reset;
    $rose(rst_n) |-> !pad_oe [*2];
  endproperty
  a_hiz_reset: assert property (p_hiz_reset) else $error("pad driven at reset");
  property p_irq_input;
    pin_irq_pulse |-> !pad_oe;
  endproperty
  a_irq_input: assert property (p_irq_input) else $error("edge event in output");
  property p_role_one;
    $onehot0(role_in);
  endproperty
  a_role_one: assert property (p_role_one) else $error("several input roles");
endmodule
`default_nettype wire

//--- tb/tb_top.sv
/*
 Bench for the pin block over its register bus.
 Assumes gp6_regs.vh on the include path.
*/
`timescale 1ns/1ns
`default_nettype none
`include "gp6_regs.vh"
module tb_top;
  logic clock = 1'h0;
  logic rst_n = 1'h0;
  logic [19:0] s_axi_awaddr = 20'h0;
  logic [19:0] s_axi_araddr = 20'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  logic ext_en = 1'h0;
  logic ext_lvl = 1'h0;
  logic [15:0] src = 16'h0;
  logic [3:0] irq_tab [4] = '{4'h6, 4'h1, 4'hf, 4'hb};
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [15:0] role_in;
  wire pad_in, pad_out, pad_oe, pull_up_en, pull_down_en, io_supply_select, pin_irq_pulse;
  logic [31:0] rd;
  logic [1:0] resp;
  int fail_count = 0;
  int compares = 0;
  int cyc = 0;
  int pulses = 0;
  int i, p;
  gp6_pin #(.LONG_CYCLES(16'h0004)) uut (.clock, .rst_n, .ce(1'h1), .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .pad_in, .pad_out, .pad_oe, .pull_up_en, .pull_down_en,
    .io_supply_select, .osc_32k_clk(src[1]), .ext_pwr_clk_2m(src[14]),
    .on_state(src[2]), .sleep_state(src[3]), .state_change(src[4]),
    .dvs_done_one(src[8]), .dvs_done_two(src[9]), .ext_pwr_en_one(src[10]),
    .ext_pwr_en_two(src[11]), .system_supply_good(src[12]),
    .converter_power_good(src[13]), .aux_reset(src[15]), .role_in, .pin_irq_pulse);
  gp6_board board (.clock, .pad_out, .pad_oe, .pull_up_en, .pull_down_en, .ext_en,
    .ext_lvl, .pad_in);
  always #4 clock = ~clock;
  always @(posedge clock) if (pin_irq_pulse === 1'h1) pulses <= pulses + 1;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      conclude();
    end
  end
  task conclude;
    if (fail_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task settle(input int n);
    repeat (n) @(posedge clock);
  endtask
  task wr(input logic [19:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      hb = 1'h0;
      while (!hb) begin
        @(negedge clock);
        ha = s_axi_awvalid & s_axi_awready;
        hw = s_axi_wvalid & s_axi_wready;
        hb = s_axi_bvalid;
        resp = s_axi_bresp;
        @(posedge clock);
        if (ha) s_axi_awvalid <= 1'h0;
        if (hw) s_axi_wvalid <= 1'h0;
      end
      s_axi_bready <= 1'h0;
      @(posedge clock);
    end
  endtask
  task rd_t(input logic [19:0] a);
    logic ha, hr;
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      hr = 1'h0;
      while (!hr) begin
        @(negedge clock);
        ha = s_axi_arvalid & s_axi_arready;
        hr = s_axi_rvalid;
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        @(posedge clock);
        if (ha) s_axi_arvalid <= 1'h0;
      end
      s_axi_rready <= 1'h0;
      @(posedge clock);
    end
  endtask
  initial begin
    settle(10);
    rst_n <= 1'h1;
    settle(1);
    rd_t(`GP6_CFG_ADDR);
    chk(rd, 32'ha400);
    chk({pad_oe, pull_up_en, pull_down_en, io_supply_select}, 32'h0);
    rd_t(20'h00008);
    chk(resp, `GP6_RESP_SLVERR);
    chk(rd, 32'h0);
    wr(20'h00008, 32'h0);
    chk(resp, `GP6_RESP_SLVERR);
    wr(`GP6_CFG_ADDR, 32'hffff);
    chk(resp, `GP6_RESP_OKAY);
    rd_t(`GP6_CFG_ADDR);
    chk(rd, 32'hfe8f);
    for (i = 0; i < 4; i++) begin
      wr(`GP6_CFG_ADDR, 32'h8480 | (i << 13));
      settle(3);
      chk({pull_up_en, pull_down_en}, (i == 1) ? 1 : (i == 2) ? 2 : 0);
    end
    wr(`GP6_CFG_ADDR, 32'h8c80);
    settle(3);
    chk(io_supply_select, 32'h1);
    ext_en <= 1'h1;
    ext_lvl <= 1'h1;
    for (i = 0; i < 16; i++) begin
      wr(`GP6_CFG_ADDR, 32'h8480 | i);
      settle(20);
      chk({pad_oe, role_in}, 32'h1 << i);
    end
    wr(`GP6_CFG_ADDR, 32'h8081);
    settle(20);
    chk(role_in, 32'h0);
    ext_lvl <= 1'h0;
    settle(20);
    chk(role_in, 32'h2);
    for (i = 0; i < 4; i++) begin
      wr(`GP6_CFG_ADDR, 32'h8081 | (irq_tab[i][3] << 12) | (irq_tab[i][2] << 10));
      settle(20);
      p = pulses;
      ext_lvl <= 1'h1;
      settle(20);
      chk(pulses - p, irq_tab[i][1]);
      p = pulses;
      ext_lvl <= 1'h0;
      settle(20);
      chk(pulses - p, irq_tab[i][0]);
    end
    ext_en <= 1'h0;
    wr(`GP6_CFG_ADDR, 32'h0480);
    wr(`GP6_LEVEL_ADDR, 32'h1);
    settle(3);
    chk({pad_oe, pad_out}, 32'h3);
    rd_t(`GP6_LEVEL_ADDR);
    chk(rd, 32'h1);
    wr(`GP6_CFG_ADDR, 32'h0080);
    settle(3);
    chk({pad_oe, pad_out}, 32'h2);
    wr(`GP6_CFG_ADDR, 32'h0680);
    settle(3);
    chk({pad_oe, pad_out}, 32'h0);
    wr(`GP6_LEVEL_ADDR, 32'h0);
    settle(3);
    chk({pad_oe, pad_out}, 32'h2);
    wr(`GP6_CFG_ADDR, 32'h0400);
    settle(3);
    chk(pad_oe, 32'h0);
    for (i = 1; i < 16; i++) begin
      wr(`GP6_CFG_ADDR, 32'h0480 | i);
      src <= 16'h1 << i;
      settle(10);
      chk(pad_out, (i < 5 || i > 7));
      src <= ~(16'h1 << i);
      settle(10);
      chk(pad_out, 32'h0);
    end
    conclude();
  end
endmodule
bind gp6_pin gp6_pin_props u_props (.clock, .rst_n, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .pad_oe, .pull_up_en, .pull_down_en,
  .role_in, .pin_irq_pulse);
`default_nettype wire

//--- verilog/gp6_pin.v
/*
 Control logic of one general-purpose pin with an AXI4-Lite register
 port. Assumes the pad cell resolves pad_out/pad_oe and applies pulls.
*/
// Operation
// - Pull field: 00 none, 01 down, 10 up, 11 reserved; resets down.
// - Edge mode 0 interrupts on logical rising edge, so polarity picks edge.
// - Edge mode 1 interrupts on both edges regardless of polarity.
// - Supply bit picks digital buffer supply (0) or alternate supply (1).
// - Polarity 0 inverts pin for input and output functions.
// - Polarity 1, the reset value, keeps pin non-inverted.
// - Driver bit: 0 push-pull, 1 open-drain; resets push-pull.
// - Enable bit 0, the reset value, keeps pin high-impedance.
// - Enable bit 1 runs pin per direction, function and driver.
// - Input codes 0 long-debounced plain input, 1 plain input.
// - Input codes 2-6: power, sleep/wake, long sleep/wake, sleep, power-on.
// - Input codes 7 watchdog reset, 8 and 9 voltage-scaling requests.
// - Input codes 10 and 11 are hardware enable inputs.
// - Input codes 12,13 hardware control; 14,15 same with long debounce.
// - Output code 0 drives programmed level, 1 the 32.768kHz clock.
// - Output codes 2 ON, 3 SLEEP, 4 state change; 5-7 reserved.
// - Output codes 8,9 scaling done; 10,11 external power enables.
// - Output code 12 system supply good, 13 converter power good.
// - Output code 14 the 2MHz power clock, 15 auxiliary reset.
`timescale 1ns/1ns
`default_nettype none
`include "gp6_regs.vh"

module gp6_pin #(
  parameter ADDR_W = 20,
  parameter CNT_W = 16,
  parameter [15:0] LONG_CYCLES = `GP6_LONG_DEB_CYCLES
) (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  input wire ce,
  // AXI4-Lite write address
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Pad
  input wire pad_in,
  output reg pad_out,
  output reg pad_oe,
  output reg pull_up_en,
  output reg pull_down_en,
  output reg io_supply_select,
  // Asynchronous clock sources for output roles
  input wire osc_32k_clk,
  input wire ext_pwr_clk_2m,
  // Same-clock output role sources
  input wire on_state,
  input wire sleep_state,
  input wire state_change,
  input wire dvs_done_one,
  input wire dvs_done_two,
  input wire ext_pwr_en_one,
  input wire ext_pwr_en_two,
  input wire system_supply_good,
  input wire converter_power_good,
  input wire aux_reset,
  // Input roles, one bit per function code
  output reg [15:0] role_in,
  output reg pin_irq_pulse
);

  localparam [1:0] WR_IDLE = 2'h0;
  localparam [1:0] WR_DO = 2'h1;
  localparam [1:0] WR_RESP = 2'h2;

  // Decoded byte addresses, compared on word bits only
  localparam [ADDR_W-1:0] CFG_BYTE = `GP6_CFG_ADDR;
  localparam [ADDR_W-1:0] LEVEL_BYTE = `GP6_LEVEL_ADDR;
  localparam [ADDR_W-1:0] STATUS_BYTE = `GP6_STATUS_ADDR;

  reg [15:0] cfg_reg;
  reg level_reg;
  reg [1:0] wr_state_reg;
  reg aw_held_reg;
  reg w_held_reg;
  reg [ADDR_W-1:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  reg in_prev_reg;
  reg in_valid_reg;

  wire [2:0] async_vec;
  wire [2:0] long_vec;
  wire [2:0] sync_vec;
  wire pin_direction;
  wire [1:0] pull_select;
  wire irq_edge_mode;
  wire pin_polarity;
  wire open_drain_select;
  wire pin_enable;
  wire [3:0] pin_function;
  wire long_deb;
  wire in_level;
  wire input_live;
  wire [15:0] cfg_next;

  assign pin_direction = cfg_reg[`PIN_DIRECTION_BIT];
  assign pull_select = cfg_reg[`PULL_SELECT_HI:`PULL_SELECT_LO];
  assign irq_edge_mode = cfg_reg[`GP6_IRQ_MODE_BIT];
  assign pin_polarity = cfg_reg[`PIN_POLARITY_BIT];
  assign open_drain_select = cfg_reg[`OPEN_DRAIN_SELECT_BIT];
  assign pin_enable = cfg_reg[`PIN_ENABLE_BIT];
  assign pin_function = cfg_reg[`PIN_FUNCTION_HI:`PIN_FUNCTION_LO];

  // Long debounce applies to codes 0, 4, 14 and 15
  assign long_deb = (pin_function == `GP6_FI_GPIO_LONG) ||
                    (pin_function == `GP6_FI_SLEEP_LONG) ||
                    (pin_function == `GP6_FI_HWCTL1_LONG) ||
                    (pin_function == `GP6_FI_HWCTL2_LONG);

  assign async_vec = {ext_pwr_clk_2m, osc_32k_clk, pad_in};
  assign long_vec = {1'b0, 1'b0, long_deb};

  // Synchronisers for the pad and the two foreign clocks
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      gp6_sync #(
        .CNT_W(CNT_W),
        .LONG_CYCLES(LONG_CYCLES)
      ) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .ce(ce),
        .async_in(async_vec[gi]),
        .long_en(long_vec[gi]),
        .level_out(sync_vec[gi])
      );
    end
  endgenerate

  // Logical input level after polarity
  assign in_level = pin_polarity ? sync_vec[0] : ~sync_vec[0];
  assign input_live = pin_enable & pin_direction;

  // Bus handshakes
  assign s_axi_awready = ~aw_held_reg & (wr_state_reg == WR_IDLE);
  assign s_axi_wready = ~w_held_reg & (wr_state_reg == WR_IDLE);
  assign s_axi_arready = ~s_axi_rvalid;

  // Byte-lane merge into the configuration register
  assign cfg_next = {w_strb_reg[1] ? w_data_reg[15:8] : cfg_reg[15:8],
                     w_strb_reg[0] ? w_data_reg[7:0] : cfg_reg[7:0]} &
                    `GP6_CFG_MASK;

  // Write channel and register storage
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_state_reg <= WR_IDLE;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= {ADDR_W{1'b0}};
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `GP6_RESP_OKAY;
      cfg_reg <= `GP6_CFG_RESET;
      level_reg <= 1'b0;
    end else if (ce) begin
      case (wr_state_reg)
        WR_IDLE: begin
          if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
          end
          if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
          end
          if ((aw_held_reg || s_axi_awvalid) && (w_held_reg || s_axi_wvalid)) begin
            wr_state_reg <= WR_DO;
          end
        end
        WR_DO: begin
          aw_held_reg <= 1'b0;
          w_held_reg <= 1'b0;
          s_axi_bvalid <= 1'b1;
          s_axi_bresp <= `GP6_RESP_OKAY;
          wr_state_reg <= WR_RESP;
          if (aw_addr_reg[ADDR_W-1:2] == CFG_BYTE[ADDR_W-1:2]) begin
            cfg_reg <= cfg_next;
          end else if (aw_addr_reg[ADDR_W-1:2] == LEVEL_BYTE[ADDR_W-1:2]) begin
            if (w_strb_reg[0]) begin
              level_reg <= w_data_reg[0];
            end
          end else if (aw_addr_reg[ADDR_W-1:2] != STATUS_BYTE[ADDR_W-1:2]) begin
            s_axi_bresp <= `GP6_RESP_SLVERR;
          end
        end
        WR_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wr_state_reg <= WR_IDLE;
          end
        end
        default: begin
          wr_state_reg <= WR_IDLE;
        end
      endcase
    end
  end

  // Read channel
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `GP6_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid <= 1'b0;
        end
      end else if (s_axi_arvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `GP6_RESP_OKAY;
        s_axi_rdata <= 32'h00000000;
        if (s_axi_araddr[ADDR_W-1:2] == CFG_BYTE[ADDR_W-1:2]) begin
          s_axi_rdata <= {16'h0000, cfg_reg};
        end else if (s_axi_araddr[ADDR_W-1:2] == LEVEL_BYTE[ADDR_W-1:2]) begin
          s_axi_rdata <= {31'h0, level_reg};
        end else if (s_axi_araddr[ADDR_W-1:2] == STATUS_BYTE[ADDR_W-1:2]) begin
          s_axi_rdata <= {28'h0000000, pad_oe, pad_out, in_level, sync_vec[0]};
        end else begin
          s_axi_rresp <= `GP6_RESP_SLVERR;
        end
      end
    end
  end

  // Pad drive, pulls and supply select
  reg src_level;
  reg drive_level;
  always @* begin
    src_level = 1'b0;
    case (pin_function)
      `GP6_FO_LEVEL: src_level = level_reg;
      `GP6_FO_CLK32K: src_level = sync_vec[1];
      `GP6_FO_ON: src_level = on_state;
      `GP6_FO_SLEEP: src_level = sleep_state;
      `GP6_FO_CHANGE: src_level = state_change;
      `GP6_FO_VOLTAGE_SCALE_REQ_ONE: src_level = dvs_done_one;
      `GP6_FO_VOLTAGE_SCALE_REQ_TWO: src_level = dvs_done_two;
      `GP6_FO_EXTEN1: src_level = ext_pwr_en_one;
      `GP6_FO_EXTEN2: src_level = ext_pwr_en_two;
      `GP6_FO_SYSTEM_SUPPLY_GOOD: src_level = system_supply_good;
      `GP6_FO_PGOOD: src_level = converter_power_good;
      `GP6_FO_CLK2M: src_level = sync_vec[2];
      `GP6_FO_AUXRST: src_level = aux_reset;
      default: src_level = 1'b0;
    endcase
    drive_level = pin_polarity ? src_level : ~src_level;
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pad_out <= 1'b0;
      pad_oe <= 1'b0;
      pull_up_en <= 1'b0;
      pull_down_en <= 1'b0;
      io_supply_select <= 1'b0;
    end else if (ce) begin
      io_supply_select <= cfg_reg[`GP6_SUPPLY_BIT];
      if (!pin_enable) begin
        pad_out <= 1'b0;
        pad_oe <= 1'b0;
        pull_up_en <= 1'b0;
        pull_down_en <= 1'b0;
      end else begin
        pull_up_en <= (pull_select == `PULL_SELECT_UP);
        pull_down_en <= (pull_select == `PULL_SELECT_DOWN);
        if (pin_direction) begin
          pad_out <= 1'b0;
          pad_oe <= 1'b0;
        end else if (open_drain_select) begin
          pad_out <= 1'b0;
          pad_oe <= ~drive_level;
        end else begin
          pad_out <= drive_level;
          pad_oe <= 1'b1;
        end
      end
    end
  end

  // Input roles and edge interrupt
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      role_in <= 16'h0000;
      pin_irq_pulse <= 1'b0;
      in_prev_reg <= 1'b0;
      in_valid_reg <= 1'b0;
    end else if (ce) begin
      in_prev_reg <= in_level;
      in_valid_reg <= input_live;
      pin_irq_pulse <= 1'b0;
      // Wait one live cycle so turning the input on gives no false edge
      if (input_live && in_valid_reg) begin
        if (irq_edge_mode) begin
          pin_irq_pulse <= in_level ^ in_prev_reg;
        end else begin
          pin_irq_pulse <= in_level & ~in_prev_reg;
        end
      end
      // One-hot role by function code
      role_in <= 16'h0000;
      if (input_live) begin
        role_in[pin_function] <= in_level;
      end
    end
  end

endmodule

`default_nettype wire

//--- verilog/gp6_sync.v
/*
 Three-stage synchroniser with agreement check and optional long
 debounce. Assumes async_in is from outside the clock domain.
*/
`timescale 1ns/1ns
`default_nettype none

module gp6_sync #(
  parameter CNT_W = 16,
  parameter [15:0] LONG_CYCLES = 16'h1000
) (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  input wire ce,
  // Signal
  input wire async_in,
  input wire long_en,
  output reg level_out
);

  reg s1_reg;
  reg s2_reg;
  reg s3_reg;
  reg agreed_reg;
  reg [CNT_W-1:0] cnt_reg;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      agreed_reg <= 1'b0;
      cnt_reg <= {CNT_W{1'b0}};
      level_out <= 1'b0;
    end else if (ce) begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        agreed_reg <= s3_reg;
      end
      if (!long_en || agreed_reg == level_out) begin
        cnt_reg <= {CNT_W{1'b0}};
        level_out <= agreed_reg;
      end else if (cnt_reg >= LONG_CYCLES[CNT_W-1:0] - 1'b1) begin
        cnt_reg <= {CNT_W{1'b0}};
        level_out <= agreed_reg;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

endmodule

`default_nettype wire
